// ---- src/cam_result_mux.sv ----
// converter sequencing, result saturation and result register file
`timescale 1ns/100ps
module cam_result_mux
    import cam_pkg::*;
#(
    parameter int OTP_CYC = OTP_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic host_convert_pin,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic adc_done,
    input wire logic signed [15:0] adc_raw,
    output logic upstream_convert_out,
    output logic adc_start_q,
    output cam_src_t adc_src_q,
    output logic adc_bandgap_q,
    output logic aux_stack_q,
    output logic busy_q,
    output logic [7:0] reg_rdata_q,
    output logic otp_prog_q,
    output logic [7:0] otp_data_q
);

    typedef struct packed {
        cam_state_t st;
        logic [3:0] pos;
        cam_src_t src;
        logic start;
        logic bandgap;
        logic aux_stack;
        logic pin;
        logic convert_request_bit_req;
        logic busy;
        logic [7:0] adc_ctrl;
        logic [7:0] func_cfg;
        logic [7:0] trim;
        logic [7:0] otp_data;
        logic [7:0] rdata;
        logic [NUM_SRC-1:0][RES_BITS-1:0] res;
    } cam_regs_t;

    cam_regs_t s_q, s_d;
    logic [2:0] ncell;
    logic [NUM_SRC-1:0] en;
    logic pin_rise;
    logic go;
    logic [3:0] first_pos;
    logic [3:0] nxt_pos;
    logic signed [16:0] corr;
    logic [13:0] clamped;
    logic otp_busy;
    logic otp_go;
    logic res_hit;
    logic [3:0] rd_slot;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // first enabled scan position at or after from
    function automatic logic [3:0] next_pos(input logic [3:0] from, input logic [8:0] m);
        logic [3:0] r;
        r = POS_NONE;
        for (int p = NUM_SRC - 1; p >= 0; p--) begin
            if (p >= int'(from) && m[p]) begin
                r = 4'(p);
            end
        end
        return r;
    endfunction

    // scan position to source: positions 0..7 are cells and thermistors, 8 is aux
    function automatic cam_src_t pos_src(input logic [3:0] p);
        return (p == POS_AUX) ? CAM_SRC_AUX : cam_src_t'(p + 4'h1);
    endfunction

    // ------------------------------------------------------------
    // scan mask
    // ------------------------------------------------------------
    // counts of zero or above six would leave the scan ill-formed, so clip them
    always_comb begin
        ncell = s_q.adc_ctrl[AC_CNT_LSB +: 3];
        if (ncell < CELL_CNT_MIN) begin
            ncell = CELL_CNT_MIN;
        end else if (ncell > CELL_CNT_MAX) begin
            ncell = CELL_CNT_MAX;
        end
        for (int k = 0; k < NUM_CELLS; k++) begin
            en[k] = 3'(k) < ncell;
        end
        en[POS_TS1] = s_q.adc_ctrl[AC_TS1_BIT];
        en[POS_TS2] = s_q.adc_ctrl[AC_TS2_BIT];
        en[POS_AUX] = s_q.adc_ctrl[AC_AUX_BIT];
    end

    // ------------------------------------------------------------
    // start and correction terms
    // ------------------------------------------------------------
    assign pin_rise = host_convert_pin && !s_q.pin;
    // the register request only counts while the pin rests low
    assign go = pin_rise || (s_q.convert_request_bit_req && !host_convert_pin);
    assign first_pos = next_pos(POS_FIRST, en);
    assign nxt_pos = next_pos(s_q.pos + 4'h1, en);
    assign corr = 17'(adc_raw) - 17'(signed'(s_q.trim));
    assign otp_go = reg_wr && reg_addr == ADDR_OTP_DATA && !otp_busy;
    assign res_hit = reg_addr >= ADDR_RES_FIRST && reg_addr <= ADDR_RES_LAST;
    assign rd_slot = 4'((reg_addr - ADDR_RES_FIRST) >> 1);

    cam_sat u_sat (
        .sum(corr),
        .res(clamped)
    );

    cam_otp_timer #(
        .CYC(OTP_CYC)
    ) u_otp (
        .mclk(mclk),
        .rst(rst),
        .start(otp_go),
        .busy(otp_busy)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.pin = host_convert_pin;

        // register writes; a convert request while the pin is high is dropped
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ADC_CTRL: s_d.adc_ctrl = reg_wdata;
                ADDR_FUNC_CFG: s_d.func_cfg = reg_wdata;
                ADDR_OFFSET_TRIM: s_d.trim = reg_wdata;
                ADDR_OTP_DATA: begin
                    if (!otp_busy) begin
                        s_d.otp_data = reg_wdata;
                    end
                end
                ADDR_CONVERT_REQUEST_BIT_CTRL: begin
                    if (reg_wdata[CC_CONVERT_REQUEST_BIT_BIT] && !host_convert_pin) begin
                        s_d.convert_request_bit_req = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // conversion sequencer
        unique case (s_q.st)
            CAM_IDLE: begin
                if (host_convert_pin) begin
                    s_d.convert_request_bit_req = 1'b0;
                end
                if (go) begin
                    s_d.convert_request_bit_req = 1'b0;
                    s_d.pos = first_pos;
                    s_d.st = CAM_REQ;
                end
            end
            CAM_REQ: begin
                s_d.src = pos_src(s_q.pos);
                s_d.start = 1'b1;
                s_d.aux_stack = s_q.func_cfg[FC_SRC_BIT];
                if (s_q.pos == POS_AUX) begin
                    // stack voltage ignores the reference choice
                    s_d.bandgap = s_q.func_cfg[FC_SRC_BIT] || s_q.func_cfg[FC_REF_BIT];
                end else begin
                    s_d.bandgap = s_q.pos < POS_TS1;
                end
                s_d.st = CAM_WAIT;
            end
            CAM_WAIT: begin
                if (adc_done) begin
                    s_d.res[s_q.src] = clamped;
                    if (nxt_pos == POS_NONE || s_q.pos == POS_AUX) begin
                        s_d.st = CAM_IDLE;
                    end else begin
                        s_d.pos = nxt_pos;
                        s_d.st = CAM_REQ;
                    end
                end
            end
            // unused code: fall back to idle rather than hang
            default: s_d.st = CAM_IDLE;
        endcase
        s_d.busy = s_d.st != CAM_IDLE;

        // read data, registered one cycle after the strobe
        if (reg_rd) begin
            s_d.rdata = 8'h00;
            if (res_hit) begin
                if (reg_addr[0]) begin
                    // odd address is the high byte of the pair
                    s_d.rdata = {RES_PAD, s_q.res[rd_slot][13:8]};
                end else begin
                    s_d.rdata = s_q.res[rd_slot][7:0];
                end
            end else begin
                unique case (reg_addr)
                    ADDR_ADC_CTRL: s_d.rdata = s_q.adc_ctrl;
                    ADDR_FUNC_CFG: s_d.rdata = s_q.func_cfg;
                    ADDR_OFFSET_TRIM: s_d.rdata = s_q.trim;
                    ADDR_OTP_DATA: s_d.rdata = s_q.otp_data;
                    ADDR_CONVERT_REQUEST_BIT_CTRL: s_d.rdata[CC_CONVERT_REQUEST_BIT_BIT] = s_q.convert_request_bit_req;
                    ADDR_STATUS: begin
                        s_d.rdata[ST_BUSY_BIT] = s_q.st != CAM_IDLE;
                        s_d.rdata[ST_OTP_BIT] = otp_busy;
                        s_d.rdata[ST_PIN_BIT] = s_q.pin;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
            s_q.adc_ctrl <= ADC_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the upstream copy is the registered pin, one cycle behind
    assign upstream_convert_out = s_q.pin;
    assign adc_start_q = s_q.start;
    assign adc_src_q = s_q.src;
    assign adc_bandgap_q = s_q.bandgap;
    assign aux_stack_q = s_q.aux_stack;
    assign busy_q = s_q.busy;
    assign reg_rdata_q = s_q.rdata;
    assign otp_prog_q = otp_busy;
    assign otp_data_q = s_q.otp_data;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_high_pad_zero: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && res_hit && reg_addr[0]) |=> reg_rdata_q[7:6] == RES_PAD)
        else $error("result high byte top bits not zero");
    a_src_range: assert property (@(posedge mclk) disable iff (rst)
        adc_start_q |-> int'(adc_src_q) < NUM_SRC) else $error("source out of range");
    a_aux_route: assert property (@(posedge mclk) disable iff (rst)
        adc_start_q |-> aux_stack_q == s_q.func_cfg[FC_SRC_BIT])
        else $error("aux route differs from config");
    a_sat_store: assert property (@(posedge mclk) disable iff (rst)
        (s_q.st == CAM_WAIT && adc_done && corr > $signed({3'h0, RES_MAX}))
        |=> s_q.res[$past(s_q.src)] == RES_MAX) else $error("overflow not held at top");
    a_sat_floor: assert property (@(posedge mclk) disable iff (rst)
        (s_q.st == CAM_WAIT && adc_done && corr < 0)
        |=> s_q.res[$past(s_q.src)] == RES_MIN) else $error("underflow not held at zero");
    a_pair_cell1: assert property (@(posedge mclk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_CELL1_LO && !(s_q.st == CAM_WAIT && adc_done))
        |=> reg_rdata_q == s_q.res[CAM_SRC_CELL1][7:0]) else $error("cell 1 low byte wrong");
    a_cell_limit: assert property (@(posedge mclk) disable iff (rst)
        (adc_start_q && adc_src_q != CAM_SRC_AUX && adc_src_q < CAM_SRC_TS1)
        |-> 3'(adc_src_q) <= ncell) else $error("scan beyond cell count");
    a_ts_enable: assert property (@(posedge mclk) disable iff (rst)
        (adc_start_q && adc_src_q == CAM_SRC_TS1) |-> s_q.adc_ctrl[AC_TS1_BIT])
        else $error("disabled thermistor converted");
    a_stack_vref: assert property (@(posedge mclk) disable iff (rst)
        (adc_start_q && adc_src_q == CAM_SRC_AUX && aux_stack_q) |-> adc_bandgap_q)
        else $error("stack voltage without bandgap");
    a_pin_start: assert property (@(posedge mclk) disable iff (rst)
        (s_q.st == CAM_IDLE && pin_rise) |=> ##1 adc_start_q)
        else $error("pin rise did not start scan");
    a_pin_blocks: assert property (@(posedge mclk) disable iff (rst)
        (s_q.st == CAM_IDLE && host_convert_pin && s_q.pin) |=> s_q.st == CAM_IDLE)
        else $error("register bit started while pin high");

    c_full_scan: cover property (@(posedge mclk) disable iff (rst)
        adc_start_q && adc_src_q == CAM_SRC_AUX);
    c_reg_start: cover property (@(posedge mclk) disable iff (rst)
        s_q.st == CAM_IDLE && s_q.convert_request_bit_req && !host_convert_pin);
    c_clamp_top: cover property (@(posedge mclk) disable iff (rst)
        s_q.st == CAM_WAIT && adc_done && corr > $signed({3'h0, RES_MAX}));
    c_otp_pulse: cover property (@(posedge mclk) disable iff (rst) otp_go);

endmodule // cam_result_mux

// ---- src/cam_pkg.sv ----
// shared constants, types and register map of the cell converter result block
package cam_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 4;
    localparam int OTP_PROG_MS = 50;
    // longest time, so the division rounds down
    localparam int OTP_PULSE_CYC = OTP_PROG_MS * 1000000 / MCLK_PERIOD_NS;

    // ------------------------------------------------------------
    // result format and sources
    // ------------------------------------------------------------
    localparam int RES_BITS = 14;
    localparam int NUM_SRC = 9;
    localparam int NUM_CELLS = 6;
    localparam logic [13:0] RES_MAX = 14'h3FFF;
    localparam logic [13:0] RES_MIN = 14'h0000;
    localparam logic [1:0] RES_PAD = 2'h0;

    // scan positions: cells first, then thermistors, then auxiliary
    localparam logic [3:0] POS_TS1 = 4'h6;
    localparam logic [3:0] POS_TS2 = 4'h7;
    localparam logic [3:0] POS_AUX = 4'h8;
    localparam logic [3:0] POS_NONE = 4'hF;
    localparam logic [3:0] POS_FIRST = 4'h0;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RES_FIRST = 8'h01;
    localparam logic [7:0] ADDR_CELL1_HI = 8'h03;
    localparam logic [7:0] ADDR_CELL1_LO = 8'h04;
    localparam logic [7:0] ADDR_RES_LAST = 8'h12;
    localparam logic [7:0] ADDR_ADC_CTRL = 8'h30;
    localparam logic [7:0] ADDR_CONVERT_REQUEST_BIT_CTRL = 8'h31;
    localparam logic [7:0] ADDR_FUNC_CFG = 8'h40;
    localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h41;
    localparam logic [7:0] ADDR_OTP_DATA = 8'h50;
    localparam logic [7:0] ADDR_STATUS = 8'h60;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int AC_CNT_LSB = 0;
    localparam int AC_TS1_BIT = 4;
    localparam int AC_TS2_BIT = 5;
    localparam int AC_AUX_BIT = 6;
    localparam int CC_CONVERT_REQUEST_BIT_BIT = 0;
    localparam int FC_SRC_BIT = 4;
    localparam int FC_REF_BIT = 6;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OTP_BIT = 1;
    localparam int ST_PIN_BIT = 2;
    localparam logic [7:0] ADC_CTRL_RST = 8'h06;
    localparam logic [2:0] CELL_CNT_MIN = 3'h1;
    localparam logic [2:0] CELL_CNT_MAX = 3'h6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CAM_SRC_AUX, CAM_SRC_CELL1, CAM_SRC_CELL2, CAM_SRC_CELL3, CAM_SRC_CELL4,
        CAM_SRC_CELL5, CAM_SRC_CELL6, CAM_SRC_TS1, CAM_SRC_TS2
    } cam_src_t;

    typedef enum logic [1:0] {CAM_IDLE, CAM_REQ, CAM_WAIT} cam_state_t;

endpackage

// ---- src/cam_sat.sv ----
// saturating clamp of an offset-corrected converter code to the result range
`timescale 1ns/100ps
module cam_sat
    import cam_pkg::*;
(
    input wire logic signed [16:0] sum,
    output logic [13:0] res
);

    // ------------------------------------------------------------
    // clamp
    // ------------------------------------------------------------
    // never wrap: a negative sum pins low, an oversize sum pins high
    always_comb begin
        if (sum < 0) begin
            res = RES_MIN;
        end else if (sum > $signed({3'h0, RES_MAX})) begin
            res = RES_MAX;
        end else begin
            res = sum[13:0];
        end
    end

endmodule // cam_sat

// ---- src/cam_otp_timer.sv ----
// self-timed write pulse for the one-time-programmable configuration
`timescale 1ns/100ps
module cam_otp_timer
    import cam_pkg::*;
#(
    parameter int CYC = OTP_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    output logic busy
);

    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
    } cam_otp_st_t;

    cam_otp_st_t s_q, s_d;

    // ------------------------------------------------------------
    // pulse counter
    // ------------------------------------------------------------
    // start while busy is dropped; the pulse length is fixed
    always_comb begin
        s_d = s_q;
        if (s_q.busy) begin
            if (s_q.cnt == CW'(CYC - 1)) begin
                s_d.busy = 1'b0;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end else if (start) begin
            s_d.busy = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_otp_bound: assert property (@(posedge mclk) disable iff (rst)
        s_q.busy |-> s_q.cnt < CW'(CYC)) else $error("otp pulse overran its count");
    a_otp_launch: assert property (@(posedge mclk) disable iff (rst)
        (start && !s_q.busy) |=> s_q.busy && s_q.cnt == '0)
        else $error("otp pulse did not start");

endmodule // cam_otp_timer

// ---- test/cam_adc_model.sv ----
// behavioural converter that answers start pulses promptly or slowly
`timescale 1ns/100ps
module cam_adc_model
    import cam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    input wire logic adc_start_q,
    input wire cam_src_t adc_src_q,
    input wire logic [143:0] raw_tab,
    output logic adc_done,
    output logic signed [15:0] adc_raw
);
    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    int cnt;
    initial begin
        adc_done = 1'b0;
        adc_raw = 16'h0000;
        cnt = 0;
    end
    // code valid only in the done cycle; inverted otherwise so stale reads show
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        adc_raw <= ~adc_raw;
        if (rst) begin
            cnt <= 0;
        end else if (adc_start_q) begin
            cnt <= slow ? 40 : 3;
        end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_raw <= raw_tab[int'(adc_src_q) * 16 +: 16];
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // cam_adc_model

// ---- test/cam_result_mux_tb.sv ----
// self-checking bench: scan order, result pairs, clamping, starts, otp pulse
`timescale 1ns/100ps
module cam_result_mux_tb
    import cam_pkg::*;
();
    localparam int OTP_SIM = 16;
    logic mclk, rst, host_convert_pin, reg_wr, reg_rd, adc_done, slow;
    logic upstream_convert_out, adc_start_q, adc_bandgap_q, aux_stack_q, busy_q, otp_prog_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, otp_data_q;
    logic signed [15:0] adc_raw;
    logic [143:0] raw_tab;
    cam_src_t adc_src_q;
    int miscompares, num_checks, seed;
    logic [3:0] seen_src[$];
    logic [1:0] seen_ref[$];
    logic [7:0] fc_tab[4] = '{8'h00, 8'h10, 8'h40, 8'h50};

    cam_result_mux #(.OTP_CYC(OTP_SIM)) dut_u (.mclk(mclk), .rst(rst),
        .host_convert_pin(host_convert_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .adc_done(adc_done), .adc_raw(adc_raw),
        .upstream_convert_out(upstream_convert_out), .adc_start_q(adc_start_q),
        .adc_src_q(adc_src_q), .adc_bandgap_q(adc_bandgap_q), .aux_stack_q(aux_stack_q),
        .busy_q(busy_q), .reg_rdata_q(reg_rdata_q), .otp_prog_q(otp_prog_q),
        .otp_data_q(otp_data_q));
    cam_adc_model adc_u (.mclk(mclk), .rst(rst), .slow(slow), .adc_start_q(adc_start_q),
        .adc_src_q(adc_src_q), .raw_tab(raw_tab), .adc_done(adc_done), .adc_raw(adc_raw));

    // ------------------------------------------------------------
    // clock, watchdog and start monitor
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // a hung handshake ends the run through the same closing task
    initial begin
        #160000;
        miscompares++;
        report_and_stop();
    end
    always @(posedge mclk) begin
        if (adc_start_q === 1'b1) begin
            seen_src.push_back(adc_src_q);
            seen_ref.push_back({adc_bandgap_q, aux_stack_q});
        end
    end

    // ------------------------------------------------------------
    // shared tasks and expectations
    // ------------------------------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        // strobes never abut: the idle cycle stands for the gap between packets
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
    // offset correction then hold at the range ends instead of wrapping
    function automatic logic [13:0] clamp14(logic signed [15:0] raw, logic signed [7:0] trim);
        logic signed [17:0] s;
        s = raw;
        s = s - trim;
        if (s < 0) return 14'h0000;
        if (s > 18'sh03FFF) return 14'h3FFF;
        return s[13:0];
    endfunction
    // bounded wait for busy to rise and then fall again
    task automatic wait_scan();
        int n;
        n = 0;
        while (busy_q !== 1'b1 && n < 6) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("busy rise", busy_q, 1'b1);
        n = 0;
        while (busy_q !== 1'b0 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("busy fall", busy_q, 1'b0);
    endtask
    task automatic pulse_len(output int n);
        int k;
        n = 0;
        for (k = 0; k < 100; k++) begin
            #1;
            if (otp_prog_q === 1'b1) n++;
            else if (n > 0) break;
            @(posedge mclk);
        end
    endtask

    // ------------------------------------------------------------
    // one scan with random setup, boundary codes and a start source
    // ------------------------------------------------------------
    task automatic run_scan(int i);
        logic [7:0] cfg, fc, hi, lo;
        logic signed [7:0] trim;
        logic [143:0] tab;
        logic [3:0] exp_src[$];
        logic [13:0] r;
        int c, s, k;
        cfg = $random(seed);
        cfg = cfg & 8'h77;
        fc = fc_tab[i % 4];
        trim = $random(seed);
        for (k = 0; k < 9; k++) tab[k * 16 +: 16] = $random(seed);
        tab[16 +: 16] = 16'h7FFF;
        tab[32 +: 16] = 16'h8000;
        tab[48 +: 16] = 16'(16383 + trim);
        tab[64 +: 16] = 16'(trim);
        if (i == 0) cfg = 8'h70;
        // make sure the forced-bandgap aux case and the over-range count occur
        if (i % 4 == 1) cfg[AC_AUX_BIT] = 1'b1;
        if (i == 2) cfg[2:0] = 3'h7;
        c = (cfg[2:0] == 3'h0) ? 1 : (cfg[2:0] == 3'h7) ? 6 : cfg[2:0];
        for (k = 1; k <= c; k++) exp_src.push_back(4'(k));
        if (cfg[AC_TS1_BIT]) exp_src.push_back(4'h7);
        if (cfg[AC_TS2_BIT]) exp_src.push_back(4'h8);
        if (cfg[AC_AUX_BIT]) exp_src.push_back(4'h0);
        @(posedge mclk);
        raw_tab <= tab;
        slow <= i[1];
        wr(ADDR_OFFSET_TRIM, trim);
        wr(ADDR_FUNC_CFG, fc);
        wr(ADDR_ADC_CTRL, cfg);
        rd(ADDR_FUNC_CFG, hi);
        check("function config", hi, fc);
        seen_src.delete();
        seen_ref.delete();
        if (i[0]) begin
            @(posedge mclk);
            host_convert_pin <= 1'b1;
            @(posedge mclk);
            #1;
            check("upstream copy", upstream_convert_out, 1'b1);
        end else begin
            wr(ADDR_CONVERT_REQUEST_BIT_CTRL, 8'h01);
        end
        wait_scan();
        if (i[0]) begin
            // register start must be dropped while the pin stays high
            wr(ADDR_CONVERT_REQUEST_BIT_CTRL, 8'h01);
            repeat (6) @(posedge mclk);
            #1;
            check("busy pin high", busy_q, 1'b0);
            rd(ADDR_CONVERT_REQUEST_BIT_CTRL, lo);
            check("request dropped", lo, 8'h00);
            rd(ADDR_STATUS, hi);
            check("status pin", hi, 8'(1 << ST_PIN_BIT));
            @(posedge mclk);
            host_convert_pin <= 1'b0;
            // a request that slipped in would start a scan once the pin falls
            repeat (6) @(posedge mclk);
            #1;
            check("busy pin low", busy_q, 1'b0);
        end
        check("scan length", seen_src.size(), exp_src.size());
        for (k = 0; k < exp_src.size() && k < seen_src.size(); k++) begin
            s = exp_src[k];
            check("scan source", seen_src[k], exp_src[k]);
            if (s == 0) begin
                check("aux ref", seen_ref[k], {fc[4] | fc[6], fc[4]});
            end else begin
                // cells convert against the bandgap, thermistors ratiometric
                check("channel ref", seen_ref[k][1], s <= NUM_CELLS);
            end
            r = clamp14(tab[s * 16 +: 16], trim);
            rd(8'(ADDR_RES_FIRST + 2 * s), hi);
            rd(8'(ADDR_RES_FIRST + 2 * s + 1), lo);
            check("result high", hi, {2'h0, r[13:8]});
            check("result low", lo, r[7:0]);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        int n;
        seed = 47944;
        rst = 1'b1;
        host_convert_pin = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        raw_tab = '0;
        slow = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(ADDR_ADC_CTRL, d);
        check("ctrl reset", d, ADC_CTRL_RST);
        rd(8'h20, d);
        check("unmapped", d, 8'h00);
        wr(ADDR_CELL1_HI, 8'hFF);
        rd(ADDR_CELL1_HI, d);
        check("read only result", d, 8'h00);
        for (n = 0; n < 8; n++) run_scan(n);
        // otp pulse length, then a write during the pulse is ignored
        wr(ADDR_OTP_DATA, 8'hA5);
        pulse_len(n);
        check("otp pulse", n, OTP_SIM);
        check("otp data", otp_data_q, 8'hA5);
        wr(ADDR_OTP_DATA, 8'h5A);
        wr(ADDR_OTP_DATA, 8'h3C);
        pulse_len(n);
        repeat (3) @(posedge mclk);
        #1;
        check("otp refused", {otp_prog_q, otp_data_q}, 9'h05A);
        report_and_stop();
    end
endmodule // cam_result_mux_tb
